// File: design/port_config_and_data_regs.v
/*
 * Configurable I/O port logic: per-port function select, direction and
 * drive select registers, data in/out, output logic cells with load mask,
 * data port, peripheral buffer and boot pattern modes.
 * Assumes host strobes and pins are synchronous to core_clk.
 */
// Functional notes
// - Data port mode on F and G disables their general-purpose I/O use.
// - Peripheral-mode bit 7 makes port F a tri-state bidirectional data buffer.
// - Peripheral buffer stays tri-state unless a peripheral select term is active.
// - Port E pins are shared with the serial programming port.
// - In boot mode, F and G drive the pattern during reset with no bus cycle.
// - After reset release, F and G stop the pattern and act as data port.
// - Configuration registers are host read/write at fixed offsets.
// - Each configuration bit acts only on the pin of the same index, except peripheral-mode bit 7, which switches all of port F.
// - Control, direction and drive select registers reset to zero.
// - On E, F, G control 0 is host I/O, 1 is address out.
// - Direction 1 makes an output, 0 an input; default input.
// - On A, B, C, F output if direction or enable term is 1.
// - Port D direction implements only four low bits.
// - Drive select 1 gives open drain where supported, else push-pull.
// - Drive select 1 gives fast slew where slew control exists.
// - Open drain on A, B, E, G, D[3:0]; slew on C, F.
// - Reading the input data register returns live pin levels.
// - Output data register holds writes, drives output pins, reads back.
// - Logic cells are host addressed; reads return outputs, writes load unmasked.
// - Mask bit 1 blocks host load of its cell; masks reset to zero.
// - E, F, G drive address only with control set and either enable term or direction.
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg_defines.vh"

module port_config_and_data_regs #(
    parameter [15:0] BOOT_PATTERN = `BOOT_DEFAULT
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        ioSel,
    input  wire        hostRd,
    input  wire        hostWr,
    input  wire [7:0]  hostAddr,
    input  wire [7:0]  hostWrData,
    output reg  [7:0]  hostRdData,
    input  wire [55:0] pinIn,
    output reg  [55:0] pinOut_ff,
    output reg  [55:0] pinOe_ff,
    output reg  [15:0] slewFast_ff,
    input  wire [55:0] oeTerm,
    input  wire [15:0] latchedAddr,
    input  wire [15:0] cellNext,
    input  wire [15:0] cellLoad,
    input  wire [15:0] cellRoute,
    output reg  [15:0] cellOut_ff,
    input  wire        dataPortMode,
    input  wire        busDrive,
    input  wire [15:0] memRdData,
    input  wire        periph_select_a,
    input  wire        periph_select_b,
    input  wire        jtagEn,
    input  wire        jtagTdo,
    input  wire        jtagTdoOe,
    input  wire        bootPatternMode,
    input  wire        mcuRst,
    input  wire        busCycle
);
    reg  [55:0] pinFunction_ff;
    reg  [55:0] pinDirection_ff;
    reg  [55:0] pinDrive_ff;
    reg  [55:0] pinOutValue_ff;
    reg  [15:0] loadBlock_ff;
    reg  [7:0]  memMapping_ff;
    reg  [55:0] nxtPinOut;
    reg  [55:0] nxtPinOe;
    wire [55:0] sliceOut;
    wire [55:0] sliceOe;
    wire [3:0]  regSel;
    wire [3:0]  portSel;
    wire        wrEn;
    wire        rdEn;
    wire        periphOn;
    wire        periphAct;
    wire        bootDrive;
    integer     i;
    integer     j;
    integer     k;

    assign regSel    = hostAddr[`SEL_HI:`SEL_LO];
    assign portSel   = hostAddr[`PRT_HI:`PRT_LO];
    assign wrEn      = ioSel & hostWr;
    assign rdEn      = ioSel & hostRd;
    assign periphOn  = memMapping_ff[`PERIPH_BIT];
    assign periphAct = periphOn & (periph_select_a | periph_select_b);
    assign bootDrive = bootPatternMode & mcuRst & ~busCycle;

    // Bits a port really has for a register kind; the rest read zero
    function [7:0] implMask;
        input [3:0] kind;
        input [3:0] prt;
        begin
            case (kind)
                `REG_DIN, `REG_DOUT, `REG_EOUT:
                    implMask = (prt == `PORT_D) ? `PORT_D_MASK : `FULL_MASK;
                `REG_DIR, `REG_DRIVE:
                    implMask = (prt == `PORT_D) ? `PORT_D_MASK
                                                : `FULL_MASK;
                `REG_CTRL:
                    implMask = (prt == `PORT_E || prt == `PORT_F ||
                                prt == `PORT_G) ? `FULL_MASK : `NONE_MASK;
                `REG_CELL, `REG_MASK:
                    implMask = (prt == `PORT_A || prt == `PORT_B) ?
                               `FULL_MASK : `NONE_MASK;
                `REG_MAP:
                    implMask = (prt == `PORT_A) ? `FULL_MASK : `NONE_MASK;
                default:
                    implMask = `NONE_MASK;
            endcase
        end
    endfunction

    // Drive select means open drain on these ports, slew rate elsewhere
    function isOdPort;
        input integer prt;
        begin
            isOdPort = (prt == `PORT_A || prt == `PORT_B || prt == `PORT_D ||
                        prt == `PORT_E || prt == `PORT_G);
        end
    endfunction

    function usesOeTerm;
        input integer prt;
        begin
            usesOeTerm = (prt == `PORT_A || prt == `PORT_B ||
                          prt == `PORT_C || prt == `PORT_F);
        end
    endfunction

    // Configuration and data registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinFunction_ff  <= {`NUM_PORTS{`CFG_RESET}};
            pinDirection_ff <= {`NUM_PORTS{`CFG_RESET}};
            pinDrive_ff     <= {`NUM_PORTS{`CFG_RESET}};
            pinOutValue_ff  <= {`NUM_PORTS{`CFG_RESET}};
            memMapping_ff   <= `CFG_RESET;
        end else if (wrEn) begin
            for (i = 0; i < `NUM_PORTS; i = i + 1) begin
                if (portSel == i[3:0]) begin
                    case (regSel)
                        `REG_CTRL:
                            pinFunction_ff[i*8 +: 8] <= hostWrData &
                                implMask(`REG_CTRL, i[3:0]);
                        `REG_DIR:
                            pinDirection_ff[i*8 +: 8] <= hostWrData &
                                implMask(`REG_DIR, i[3:0]);
                        `REG_DRIVE:
                            pinDrive_ff[i*8 +: 8] <= hostWrData &
                                implMask(`REG_DRIVE, i[3:0]);
                        `REG_DOUT:
                            pinOutValue_ff[i*8 +: 8] <= hostWrData &
                                implMask(`REG_DOUT, i[3:0]);
                        default: ;
                    endcase
                end
            end
            if (regSel == `REG_MAP && portSel == `PORT_A) begin
                memMapping_ff <= hostWrData;
            end
        end
    end

    // Output logic cells; an unmasked host write beats the array load
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cellOut_ff   <= `CELL_RESET;
            loadBlock_ff <= `CELL_RESET;
        end else begin
            for (k = 0; k < `CELL_BITS; k = k + 1) begin
                if (wrEn && regSel == `REG_CELL && portSel == k[6:3] &&
                    !loadBlock_ff[k]) begin
                    cellOut_ff[k] <= hostWrData[k % 8];
                end else if (cellLoad[k]) begin
                    cellOut_ff[k] <= cellNext[k];
                end
            end
            if (wrEn && regSel == `REG_MASK) begin
                if (portSel == `PORT_A)
                    loadBlock_ff[7:0] <= hostWrData;
                else if (portSel == `PORT_B)
                    loadBlock_ff[15:8] <= hostWrData;
            end
        end
    end

    // Per-port output selection
    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
            wire [7:0] forceOe;
            wire [7:0] forceData;
            wire       forceEn;
            wire [7:0] odBits;
            wire [7:0] addrBits;
            wire [7:0] cellBits;
            wire [7:0] routeBits;

            assign odBits = isOdPort(p) ?
                pinDrive_ff[p*8 +: 8] & implMask(`REG_DRIVE, p) : `NONE_MASK;
            assign addrBits = (p == `PORT_G) ? latchedAddr[15:8]
                                             : latchedAddr[7:0];
            assign cellBits  = (p == `PORT_B) ? cellOut_ff[15:8] : cellOut_ff[7:0];
            assign routeBits = (p == `PORT_A) ? cellRoute[7:0] :
                               (p == `PORT_B) ? cellRoute[15:8] : `NONE_MASK;

            if (p == `PORT_F || p == `PORT_G) begin : g_bus
                wire [7:0] busByte;
                wire [7:0] bootByte;
                wire [7:0] modeOe;
                assign busByte  = (p == `PORT_G) ? memRdData[15:8] : memRdData[7:0];
                assign bootByte = (p == `PORT_G) ? BOOT_PATTERN[15:8]
                                                 : BOOT_PATTERN[7:0];
                // Data port: pins are the host data bus, no GPIO at all
                assign modeOe = bootDrive ? `FULL_MASK :
                                dataPortMode ? {8{busDrive}} :
                                (p == `PORT_F && periphAct && hostWr) ?
                                    `FULL_MASK : `NONE_MASK;
                // Pattern ends with mcuRst, handing back to data port
                assign forceEn = bootDrive | dataPortMode |
                                 (p == `PORT_F && periphOn);
                assign forceOe = modeOe;
                assign forceData = bootDrive ? bootByte :
                                   dataPortMode ? busByte : hostWrData;
            end else if (p == `PORT_E) begin : g_jtag
                // Programming never overlaps normal use, so pins are shared
                assign forceEn = jtagEn;
                assign forceOe = {{(7-`JTAG_TDO_BIT){1'b0}}, jtagTdoOe,
                                  {`JTAG_TDO_BIT{1'b0}}};
                assign forceData = {{(7-`JTAG_TDO_BIT){1'b0}}, jtagTdo,
                                    {`JTAG_TDO_BIT{1'b0}}};
            end else begin : g_plain
                assign forceEn   = 1'b0;
                assign forceOe   = `NONE_MASK;
                assign forceData = `NONE_MASK;
            end

            pin_drive_slice u_slice (
                .dataOut    (pinOutValue_ff[p*8 +: 8]),
                .dirBits    (pinDirection_ff[p*8 +: 8]),
                .oeTerm     (oeTerm[p*8 +: 8] & implMask(`REG_DIR, p)),
                .oeTermUsed (usesOeTerm(p)),
                .ctrlBits   (pinFunction_ff[p*8 +: 8]),
                .addrBits   (addrBits),
                .cellBits   (cellBits),
                .cellRoute  (routeBits),
                .openDrain  (odBits),
                .forceEn    (forceEn),
                .forceOe    (forceOe),
                .forceData  (forceData),
                .nxtOut     (sliceOut[p*8 +: 8]),
                .nxtOe      (sliceOe[p*8 +: 8])
            );
        end
    endgenerate

    always @* begin
        nxtPinOut = sliceOut;
        nxtPinOe  = sliceOe;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinOut_ff   <= {`NUM_PORTS{`CFG_RESET}};
            pinOe_ff    <= {`NUM_PORTS{`CFG_RESET}};
            slewFast_ff <= {`CFG_RESET, `CFG_RESET};
        end else begin
            pinOut_ff   <= nxtPinOut;
            pinOe_ff    <= nxtPinOe;
            slewFast_ff <= {pinDrive_ff[`PORT_F*8 +: 8],
                            pinDrive_ff[`PORT_C*8 +: 8]};
        end
    end

    // Register read path, combinational within the read cycle
    always @* begin
        hostRdData = `NONE_MASK;
        if (rdEn) begin
            for (j = 0; j < `NUM_PORTS; j = j + 1) begin
                if (portSel == j[3:0]) begin
                    case (regSel)
                        `REG_DIN:   hostRdData = pinIn[j*8 +: 8];
                        `REG_DOUT:  hostRdData = pinOutValue_ff[j*8 +: 8];
                        `REG_DIR:   hostRdData = pinDirection_ff[j*8 +: 8];
                        `REG_DRIVE: hostRdData = pinDrive_ff[j*8 +: 8];
                        `REG_CTRL:  hostRdData = pinFunction_ff[j*8 +: 8];
                        `REG_EOUT:  hostRdData = pinOe_ff[j*8 +: 8];
                        default:    hostRdData = `NONE_MASK;
                    endcase
                    hostRdData = hostRdData & implMask(regSel, j[3:0]);
                end
            end
            if (regSel == `REG_CELL && portSel == `PORT_A)
                hostRdData = cellOut_ff[7:0];
            if (regSel == `REG_CELL && portSel == `PORT_B)
                hostRdData = cellOut_ff[15:8];
            if (regSel == `REG_MASK && portSel == `PORT_A)
                hostRdData = loadBlock_ff[7:0];
            if (regSel == `REG_MASK && portSel == `PORT_B)
                hostRdData = loadBlock_ff[15:8];
            if (regSel == `REG_MAP && portSel == `PORT_A)
                hostRdData = memMapping_ff;
        end else if (hostRd && periphAct) begin
            hostRdData = pinIn[`PORT_F*8 +: 8];
        end
    end
endmodule // port_config_and_data_regs

`default_nettype wire

// File: inc/port_cfg_defines.vh
/*
 * Register selectors, port indices, bit positions and reset values of the
 * port configuration and data registers. Assumes inclusion by bare name.
 */
`ifndef PORT_CFG_DEFINES_VH
`define PORT_CFG_DEFINES_VH

// Address layout: upper nibble picks the register kind, lower the port
`define SEL_HI        7
`define SEL_LO        4
`define PRT_HI        3
`define PRT_LO        0

`define REG_DIN       4'h0
`define REG_DOUT      4'h1
`define REG_DIR       4'h2
`define REG_DRIVE     4'h3
`define REG_CTRL      4'h4
`define REG_CELL      4'h5
`define REG_MASK      4'h6
`define REG_MAP       4'h7
`define REG_EOUT      4'h8

`define PORT_A        4'h0
`define PORT_B        4'h1
`define PORT_C        4'h2
`define PORT_D        4'h3
`define PORT_E        4'h4
`define PORT_F        4'h5
`define PORT_G        4'h6

`define NUM_PORTS     7
`define PIN_BITS      56
`define CELL_BITS     16

`define CFG_RESET     8'h00
`define CELL_RESET    16'h0000
`define FULL_MASK     8'hff
`define NONE_MASK     8'h00
`define PORT_D_MASK   8'h0f
`define PERIPH_BIT    7
`define JTAG_TDO_BIT  3
`define BOOT_DEFAULT  16'h0000

`endif

// File: design/pin_drive_slice.v
/*
 * Output selection for one 8-pin port: host I/O, latched address out,
 * logic cell outputs, forced modes and open-drain shaping.
 * Assumes the caller registers the results before they reach the pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg_defines.vh"

module pin_drive_slice (
    input  wire [7:0] dataOut,
    input  wire [7:0] dirBits,
    input  wire [7:0] oeTerm,
    input  wire       oeTermUsed,
    input  wire [7:0] ctrlBits,
    input  wire [7:0] addrBits,
    input  wire [7:0] cellBits,
    input  wire [7:0] cellRoute,
    input  wire [7:0] openDrain,
    input  wire       forceEn,
    input  wire [7:0] forceOe,
    input  wire [7:0] forceData,
    output reg  [7:0] nxtOut,
    output reg  [7:0] nxtOe
);
    reg [7:0] oeTermEff;
    reg [7:0] rawOut;
    reg [7:0] rawOe;
    integer   b;

    always @* begin
        oeTermEff = oeTermUsed ? oeTerm : `NONE_MASK;
        rawOut    = `NONE_MASK;
        rawOe     = `NONE_MASK;
        for (b = 0; b < 8; b = b + 1) begin
            if (ctrlBits[b]) begin
                rawOut[b] = addrBits[b];
                rawOe[b]  = oeTerm[b] | dirBits[b];
            end else begin
                rawOut[b] = cellRoute[b] ? cellBits[b] : dataOut[b];
                rawOe[b]  = dirBits[b] | oeTermEff[b];
            end
        end
        if (forceEn) begin
            nxtOut = forceData;
            nxtOe  = forceOe;
        end else begin
            // Open drain only ever pulls low; a high is left to the pull-up
            nxtOut = rawOut & ~openDrain;
            nxtOe  = rawOe & ~(openDrain & rawOut);
        end
    end
endmodule // pin_drive_slice

`default_nettype wire

// File: tb/port_cfg_monitor.sv
/*
 * Checker for the port configuration and data registers: pin drive modes,
 * read path and output cell load blocking.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none

module port_cfg_monitor #(
    parameter logic [15:0] BOOT_PATTERN = 16'h0000
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        ioSel,
    input wire logic        hostRd,
    input wire logic        hostWr,
    input wire logic [7:0]  hostAddr,
    input wire logic [7:0]  hostWrData,
    input wire logic [7:0]  hostRdData,
    input wire logic [55:0] pinIn,
    input wire logic [55:0] pinOut_ff,
    input wire logic [55:0] pinOe_ff,
    input wire logic [15:0] cellLoad,
    input wire logic [15:0] cellOut_ff,
    input wire logic        dataPortMode,
    input wire logic        busDrive,
    input wire logic [15:0] memRdData,
    input wire logic        periph_select_a,
    input wire logic        periph_select_b,
    input wire logic        jtagEn,
    input wire logic        jtagTdo,
    input wire logic        jtagTdoOe,
    input wire logic        bootPatternMode,
    input wire logic        mcuRst,
    input wire logic        busCycle
);
    // Shadow copies, since the mode and mask registers are not visible here
    logic       periphOn_ff;
    logic [7:0] maskA_ff;
    wire        bootOn = bootPatternMode & mcuRst & ~busCycle;
    wire        wrHit  = ioSel & hostWr;
    wire  [7:0] cellA  = cellOut_ff[7:0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periphOn_ff <= 1'b0;
            maskA_ff    <= 8'h00;
        end else if (wrHit) begin
            if (hostAddr == 8'h70)
                periphOn_ff <= hostWrData[7];
            if (hostAddr == 8'h60)
                maskA_ff <= hostWrData;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence bootDrive;
        bootOn;
    endsequence
    sequence cellWriteA;
        wrHit && hostAddr == 8'h50 && cellLoad[7:0] == 8'h00;
    endsequence

    chk_boot_drive: assert property (
        bootDrive |=> pinOe_ff[55:40] == 16'hffff && pinOut_ff[55:40] == BOOT_PATTERN)
        else $error("boot pattern not driven");
    chk_port_release: assert property (
        !bootOn && dataPortMode && !busDrive |=> pinOe_ff[55:40] == 16'h0000)
        else $error("data port drives while idle");
    chk_data_drive: assert property (
        !bootOn && dataPortMode && busDrive |=> pinOe_ff[55:40] == 16'hffff
        && pinOut_ff[55:40] == $past(memRdData)) else $error("data port value wrong");
    chk_periph_idle: assert property (
        periphOn_ff && !periph_select_a && !periph_select_b && !dataPortMode && !bootOn
        |=> pinOe_ff[47:40] == 8'h00) else $error("buffer not tri-stated");
    chk_read_idle: assert property (
        !hostRd |-> hostRdData == 8'h00) else $error("read data without read");
    chk_din_read: assert property (
        ioSel && hostRd && hostAddr[7:4] == 4'h0 && hostAddr[3:0] < 4'h7 && hostAddr[3:0] != 4'h3
        |-> hostRdData == pinIn[{hostAddr[2:0], 3'b000} +: 8]) else $error("data in not live");
    chk_dir_narrow: assert property (
        ioSel && hostRd && hostAddr == 8'h23 |-> hostRdData[7:4] == 4'h0)
        else $error("port D direction too wide");
    chk_jtag_hold: assert property (
        jtagEn && jtagTdoOe |=> pinOe_ff[35] && pinOut_ff[35] == $past(jtagTdo)
        && (pinOe_ff[39:32] & 8'hf7) == 8'h00) else $error("programming port share wrong");
    chk_cell_mask: assert property (
        cellWriteA |=> cellA == (($past(hostWrData) & ~$past(maskA_ff))
        | ($past(cellA) & $past(maskA_ff)))) else $error("cell load ignores mask");
endmodule // port_cfg_monitor

bind port_config_and_data_regs port_cfg_monitor #(.BOOT_PATTERN(BOOT_PATTERN)) u_port_cfg_monitor (
    .core_clk, .rst, .ioSel, .hostRd, .hostWr, .hostAddr, .hostWrData, .hostRdData, .pinIn,
    .pinOut_ff, .pinOe_ff, .cellLoad, .cellOut_ff, .dataPortMode, .busDrive, .memRdData,
    .periph_select_a, .periph_select_b, .jtagEn, .jtagTdo, .jtagTdoOe, .bootPatternMode,
    .mcuRst, .busCycle);

`default_nettype wire

// File: tb/pin_world.sv
/*
 * Far side of the ports: pin levels seen by the input buffers, and the
 * host sampling the data bus as its reset ends.
 * Assumes the bench supplies the level of every pin nobody drives.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_world (
    input  wire logic [55:0] pinOut_ff,
    input  wire logic [55:0] pinOe_ff,
    input  wire logic [55:0] extLevel,
    input  wire logic        mcuRst,
    output wire logic [55:0] pinLevel,
    output var  logic [15:0] bootSample
);
    // Released pins show the outside level, never the last driven value
    assign pinLevel = (pinOut_ff & pinOe_ff) | (extLevel & ~pinOe_ff);

    // One process owns the sample, so it has a single driver
    initial begin
        bootSample = 16'h0000;
        forever @(negedge mcuRst) bootSample = pinLevel[55:40];
    end
endmodule // pin_world

`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench for the port configuration and data registers.
 * Assumes the checker is bound in and the pin model closes the pin loop.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin badCount++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

module testbench;
    localparam logic [15:0] BOOT = 16'h5a3c;
    logic        core_clk, rst, ioSel, hostRd, hostWr, dataPortMode, busDrive;
    logic        periph_select_a, periph_select_b, jtagEn, jtagTdo, jtagTdoOe;
    logic        bootPatternMode, mcuRst, busCycle;
    logic [7:0]  hostAddr, hostWrData;
    logic [55:0] oeTerm, extLevel;
    logic [15:0] latchedAddr, cellNext, cellLoad, cellRoute, memRdData;
    wire  [7:0]  hostRdData;
    wire  [55:0] pinIn, pinOut_ff, pinOe_ff;
    wire  [15:0] slewFast_ff, cellOut_ff, bootSample;
    int          badCount, nChecks;

    port_config_and_data_regs #(.BOOT_PATTERN(BOOT)) u_port_config_and_data_regs (
        .core_clk, .rst, .ioSel, .hostRd, .hostWr, .hostAddr, .hostWrData, .hostRdData,
        .pinIn, .pinOut_ff, .pinOe_ff, .slewFast_ff, .oeTerm, .latchedAddr, .cellNext,
        .cellLoad, .cellRoute, .cellOut_ff, .dataPortMode, .busDrive, .memRdData,
        .periph_select_a, .periph_select_b, .jtagEn, .jtagTdo, .jtagTdoOe,
        .bootPatternMode, .mcuRst, .busCycle);
    pin_world u_pin_world (.pinOut_ff, .pinOe_ff, .extLevel, .mcuRst, .pinLevel(pinIn),
        .bootSample);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Idle cycle after each access keeps strobes from toggling twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {ioSel, hostWr, hostAddr, hostWrData} = {2'b11, a, d};
        step(1);
        {ioSel, hostWr} = 2'b00;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        {ioSel, hostRd, hostAddr} = {2'b11, a};
        #10;
        `CHK("register read", e, hostRdData)
        step(1);
        {ioSel, hostRd} = 2'b00;
        step(1);
    endtask
    // Output value only matters on driven pins
    task automatic pins(input int p, input logic [7:0] eOut, input logic [7:0] eOe);
        step(2);
        `CHK("pin enable", eOe, pinOe_ff[p*8 +: 8])
        `CHK("pin value", eOut & eOe, pinOut_ff[p*8 +: 8] & eOe)
    endtask
    task automatic finalReport;
        $display("Comparisons %0d, mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        badCount++;
        finalReport;
    end

    initial begin
        rst = 1'b1;
        {ioSel, hostRd, hostWr, dataPortMode, busDrive, periph_select_a, periph_select_b} = '0;
        {jtagEn, jtagTdo, jtagTdoOe, bootPatternMode, mcuRst, busCycle} = '0;
        {hostAddr, hostWrData, cellNext, cellLoad, cellRoute, memRdData, oeTerm} = '0;
        extLevel = 56'h003c0000009600;
        latchedAddr = 16'hc3e1;
        step(2);
        rst = 1'b0;
        step(1);
        for (int k = 2; k <= 4; k++)
            for (int p = 0; p < 7; p++)
                rd({k[3:0], p[3:0]}, 8'h00);
        rd(8'h60, 8'h00);
        wr(8'h25, 8'hff);
        wr(8'h15, 8'ha5);
        pins(5, 8'ha5, 8'hff);
        rd(8'h85, 8'hff);
        pins(4, 8'h00, 8'h00);
        rd(8'h15, 8'ha5);
        rd(8'h05, 8'ha5);
        rd(8'h01, 8'h96);
        wr(8'h23, 8'hff);
        rd(8'h23, 8'h0f);
        pins(3, 8'h00, 8'h0f);
        oeTerm[7:0] = 8'h3c;
        pins(0, 8'h00, 8'h3c);
        oeTerm[7:0] = 8'h00;
        wr(8'h30, 8'hff);
        wr(8'h20, 8'hff);
        wr(8'h10, 8'h0f);
        pins(0, 8'h00, 8'hf0);
        wr(8'h32, 8'h81);
        wr(8'h35, 8'h42);
        `CHK("slew select", 16'h4281, slewFast_ff)
        pins(5, 8'ha5, 8'hff);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        wr(8'h44, 8'hff);
        wr(8'h24, 8'hff);
        pins(4, 8'he1, 8'hff);
        wr(8'h46, 8'hff);
        pins(6, 8'h00, 8'h00);
        {jtagEn, jtagTdoOe, jtagTdo} = 3'b111;
        pins(4, 8'h08, 8'h08);
        jtagEn = 1'b0;
        wr(8'h60, 8'h0f);
        rd(8'h60, 8'h0f);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'hf0);
        // Masked cells still take the array load
        {cellNext, cellLoad} = {16'h000f, 16'h000f};
        step(1);
        cellLoad = '0;
        rd(8'h50, 8'hff);
        wr(8'h62, 8'hff);
        rd(8'h62, 8'h00);
        wr(8'h70, 8'h80);
        pins(5, 8'h00, 8'h00);
        {periph_select_a, hostRd} = 2'b11;
        #10;
        `CHK("buffer read", 8'h3c, hostRdData)
        step(1);
        {hostRd, hostWr, hostWrData} = {2'b01, 8'h77};
        step(1);
        `CHK("buffer enable", 8'hff, pinOe_ff[47:40])
        `CHK("buffer value", 8'h77, pinOut_ff[47:40])
        {hostWr, periph_select_a} = 2'b00;
        step(1);
        wr(8'h70, 8'h00);
        {bootPatternMode, mcuRst, dataPortMode} = 3'b111;
        pins(5, BOOT[7:0], 8'hff);
        pins(6, BOOT[15:8], 8'hff);
        busCycle = 1'b1;
        pins(5, 8'h00, 8'h00);
        busCycle = 1'b0;
        step(2);
        mcuRst = 1'b0;
        // Let the pin model take its sample first
        #1;
        `CHK("boot sample", BOOT, bootSample)
        pins(6, 8'h00, 8'h00);
        {memRdData, busDrive} = {16'hbeef, 1'b1};
        pins(5, 8'hef, 8'hff);
        pins(6, 8'hbe, 8'hff);
        {dataPortMode, busDrive, bootPatternMode} = 3'b000;
        pins(5, 8'ha5, 8'hff);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
        rd(8'h25, 8'h00);
        finalReport;
    end
endmodule // testbench

`default_nettype wire
